// [rtl/dsc_pkg.sv]
// Purpose: constants for the display scaler configuration register bank
// Assumes: byte-wide register port driven by the two-wire serial slave engine
// Notes:   offsets are byte register addresses on the serial bus
package dsc_pkg;
    // -------------------------------------------------------------------
    // register offsets
    // -------------------------------------------------------------------
    localparam logic [7:0] DSC_OFF_CTRL  = 8'h08;
    localparam logic [7:0] DSC_OFF_SENSE = 8'h09;
    localparam logic [7:0] DSC_OFF_DEPOL = 8'h0A;
    localparam logic [7:0] DSC_OFF_SNAP  = 8'h0B;
    localparam logic [7:0] DSC_OFF_PANEL = 8'h0C;
    localparam logic [7:0] DSC_OFF_STRAP = 8'h0D;
    localparam logic [7:0] DSC_OFF_RSV0  = 8'h0E;
    localparam logic [7:0] DSC_OFF_RSV1  = 8'h0F;
    // -------------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------------
    localparam logic [7:0] DSC_RST_CTRL  = 8'h39;
    localparam logic [7:0] DSC_RST_SENSE = 8'h95;
    localparam logic [7:0] DSC_RST_DEPOL = 8'h81;
    localparam logic [7:0] DSC_RST_ZERO  = 8'h00;
    // -------------------------------------------------------------------
    // writable bit masks per register
    // -------------------------------------------------------------------
    localparam logic [7:0] DSC_WM_CTRL   = 8'h3D;
    localparam logic [7:0] DSC_WM_SENSE  = 8'h78;
    localparam logic [7:0] DSC_WM_PANEL  = 8'hF0;
    localparam logic [7:0] DSC_WM_STRAP  = 8'hF0;
    localparam logic [7:0] DSC_WM_ALL    = 8'hFF;
    // -------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------
    localparam int DSC_B_RUN     = 0;
    localparam int DSC_B_BYPASS  = 2;
    localparam int DSC_B_CLKSEL  = 3;
    localparam int DSC_B_HPASS   = 4;
    localparam int DSC_B_VPASS   = 5;
    localparam int DSC_B_IRQ     = 0;
    localparam int DSC_B_RSENSE  = 2;
    localparam int DSC_B_ISRC    = 3;
    localparam int DSC_B_MONITOR_PIN_SOURCE_SELECT_LO = 4;
    localparam int DSC_B_LOW_SWING_REFERENCE_FLAG    = 7;
    localparam int DSC_B_DEPOL   = 0;
    localparam int DSC_B_LOCK    = 2;
    // -------------------------------------------------------------------
    // monitor pin sources and pixel modes
    // -------------------------------------------------------------------
    localparam logic [2:0] DSC_MON_OFF   = 3'h0;
    localparam logic [2:0] DSC_MON_IRQ   = 3'h1;
    localparam logic [2:0] DSC_MON_SENSE = 3'h2;
    localparam logic [1:0] DSC_PM_SINGLE_IN_SINGLE_OUT = 2'h0;
    localparam logic [1:0] DSC_PM_SINGLE_IN_DUAL_OUT   = 2'h1;
    localparam logic [1:0] DSC_PM_DUAL_IN_DUAL_OUT     = 2'h3;
endpackage : dsc_pkg

// [rtl/dsc_regs.sv]
// Purpose: configuration and status register bank of the display transmitter
// Assumes: serial protocol engine delivers one byte access per strobe on clk_in
// Notes:   address auto-increments after every accepted or refused data byte

module dsc_regs (
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    // register port from the serial engine
    input  wire logic       addr_load_in,
    input  wire logic [7:0] addr_in,
    input  wire logic       wr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    output logic            ack_out,
    output logic            rvalid_out,
    // pins and internal status (asynchronous)
    input  wire logic [1:0] pixel_mode_in,
    input  wire logic [3:0] panel_identifier_pins_in,
    input  wire logic       receiver_sense_in,
    input  wire logic       low_swing_ref_in,
    input  wire logic       pll_lock_in,
    input  wire logic [7:0] input_data_high_in,
    input  wire logic       hsync_in,
    input  wire logic       vsync_in,
    input  wire logic       de_in,
    // controls toward the datapath
    output logic            soft_power_down_out,
    output logic            scaler_bypass_out,
    output logic            clock_input_type_select_out,
    output logic            hsync_out,
    output logic            vsync_out,
    output logic            de_active_out,
    output logic            monitor_pin_output_out
);
    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    typedef struct packed {
        // host pointer and stored registers
        logic [7:0] addr;
        logic [7:0] ctrl;
        logic [7:0] sense;
        logic [7:0] depol;
        logic [7:0] panel;
        logic [7:0] strap;
        logic [7:0] rsv0;
        logic [7:0] rsv1;

        // two-flop synchronisers for the pins
        logic [1:0] pm_s1;
        logic [1:0] pm_s2;
        logic [3:0] id_s1;
        logic [3:0] id_s2;
        logic [2:0] st_s1;
        logic [2:0] st_s2;
        logic [7:0] dat_s1;
        logic [7:0] dat_s2;
        logic [2:0] vid_s1;
        logic [2:0] vid_s2;

        // host port answers
        logic [7:0] rdata;
        logic       ack;
        logic       rvalid;

        // datapath controls
        logic       pd;
        logic       byp;
        logic       clksel;
        logic       hs;
        logic       vs;
        logic       de;
        logic       mon;
    } dsc_state_t;

    dsc_state_t s_q;
    dsc_state_t s_d;

    logic       sense_now;
    logic       irq_now;
    logic       pm_valid_byp;
    logic [2:0] monitor_pin_source_select;
    logic [7:0] wmask;

    // -------------------------------------------------------------------
    // read data mux
    // -------------------------------------------------------------------
    // status bits are inserted live so a read never shows a stale copy
    function automatic logic [7:0] dsc_rd_mux(input dsc_state_t s, input logic irq,
                                              input logic sns);
        logic [7:0] v;
        v = dsc_pkg::DSC_RST_ZERO;
        unique case (s.addr)
            dsc_pkg::DSC_OFF_CTRL: begin
                v = s.ctrl;
            end
            dsc_pkg::DSC_OFF_SENSE: begin
                v = s.sense & dsc_pkg::DSC_WM_SENSE;
                v[dsc_pkg::DSC_B_IRQ]    = irq;
                v[dsc_pkg::DSC_B_RSENSE] = sns;
                v[dsc_pkg::DSC_B_LOW_SWING_REFERENCE_FLAG]   = s.st_s2[1];
            end
            dsc_pkg::DSC_OFF_DEPOL: begin
                v = s.depol;
            end
            dsc_pkg::DSC_OFF_SNAP: begin
                v = s.dat_s2;
            end
            dsc_pkg::DSC_OFF_PANEL: begin
                v = {s.panel[7:4], s.id_s2};
            end
            dsc_pkg::DSC_OFF_STRAP: begin
                v = s.strap & dsc_pkg::DSC_WM_STRAP;
                v[1:0] = s.pm_s2;
                v[dsc_pkg::DSC_B_LOCK] = s.st_s2[2];
            end
            dsc_pkg::DSC_OFF_RSV0: begin
                v = s.rsv0;
            end
            dsc_pkg::DSC_OFF_RSV1: begin
                v = s.rsv1;
            end
            default: begin
                // unmapped locations read as zero
                v = dsc_pkg::DSC_RST_ZERO;
            end
        endcase
        return v;
    endfunction : dsc_rd_mux

    // -------------------------------------------------------------------
    // write and control helpers
    // -------------------------------------------------------------------
    // writable bits per register; zero marks one that takes no store
    function automatic logic [7:0] dsc_wmask(input logic [7:0] a);
        logic [7:0] m;
        m = dsc_pkg::DSC_RST_ZERO;
        unique case (a)
            dsc_pkg::DSC_OFF_CTRL: begin
                m = dsc_pkg::DSC_WM_CTRL;
            end
            dsc_pkg::DSC_OFF_SENSE: begin
                m = dsc_pkg::DSC_WM_SENSE;
            end
            dsc_pkg::DSC_OFF_DEPOL: begin
                m = dsc_pkg::DSC_WM_ALL;
            end
            dsc_pkg::DSC_OFF_PANEL: begin
                m = dsc_pkg::DSC_WM_PANEL;
            end
            dsc_pkg::DSC_OFF_STRAP: begin
                m = dsc_pkg::DSC_WM_STRAP;
            end
            dsc_pkg::DSC_OFF_RSV0: begin
                m = dsc_pkg::DSC_WM_ALL;
            end
            dsc_pkg::DSC_OFF_RSV1: begin
                m = dsc_pkg::DSC_WM_ALL;
            end
            default: begin
                m = dsc_pkg::DSC_RST_ZERO;
            end
        endcase
        return m;
    endfunction : dsc_wmask

    function automatic logic [7:0] dsc_merge(input logic [7:0] old_v,
                                             input logic [7:0] new_v,
                                             input logic [7:0] mask);
        logic [7:0] r;
        r = (old_v & ~mask) | (new_v & mask);
        return r;
    endfunction : dsc_merge

    // bypass is honoured only in the two single-input pixel modes
    function automatic logic dsc_byp_ok(input logic [1:0] pm);
        logic ok;
        ok = (pm == dsc_pkg::DSC_PM_SINGLE_IN_SINGLE_OUT)
           | (pm == dsc_pkg::DSC_PM_SINGLE_IN_DUAL_OUT);
        return ok;
    endfunction : dsc_byp_ok

    // select one holds the stored interrupt bit instead of the live sense
    function automatic logic dsc_irq_pick(input logic [7:0] cfg, input logic sns);
        logic irq;
        if (cfg[dsc_pkg::DSC_B_ISRC]) begin
            irq = cfg[dsc_pkg::DSC_B_IRQ];
        end else begin
            irq = sns;
        end
        return irq;
    endfunction : dsc_irq_pick

    // reserved source codes keep the pin low
    function automatic logic dsc_mon_pick(input logic [2:0] sel, input logic irq,
                                          input logic sns);
        logic m;
        m = 1'b0;
        unique case (sel)
            dsc_pkg::DSC_MON_OFF: begin
                m = 1'b0;
            end
            dsc_pkg::DSC_MON_IRQ: begin
                m = irq;
            end
            dsc_pkg::DSC_MON_SENSE: begin
                m = sns;
            end
            default: begin
                m = 1'b0;
            end
        endcase
        return m;
    endfunction : dsc_mon_pick

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    always_comb begin
        s_d        = s_q;
        s_d.ack    = 1'b0;
        s_d.rvalid = 1'b0;

        // ---------------------------------------------------------------
        // pin synchronisers
        // ---------------------------------------------------------------
        s_d.pm_s1  = pixel_mode_in;
        s_d.pm_s2  = s_q.pm_s1;
        s_d.id_s1  = panel_identifier_pins_in;
        s_d.id_s2  = s_q.id_s1;
        s_d.st_s1  = {pll_lock_in, low_swing_ref_in, receiver_sense_in};
        s_d.st_s2  = s_q.st_s1;
        s_d.dat_s1 = input_data_high_in;
        s_d.dat_s2 = s_q.dat_s1;
        s_d.vid_s1 = {de_in, vsync_in, hsync_in};
        s_d.vid_s2 = s_q.vid_s1;

        // ---------------------------------------------------------------
        // live status
        // ---------------------------------------------------------------
        sense_now = s_q.st_s2[0];
        irq_now   = dsc_irq_pick(s_q.sense, sense_now);
        monitor_pin_source_select      = s_q.sense[dsc_pkg::DSC_B_MONITOR_PIN_SOURCE_SELECT_LO +: 3];
        wmask     = dsc_wmask(s_q.addr);

        // ---------------------------------------------------------------
        // host port, never gated by power-down
        // ---------------------------------------------------------------
        if (addr_load_in) begin
            s_d.addr = addr_in;
        end else if (wr_in) begin
            s_d.ack  = 1'b1;
            unique case (s_q.addr)
                dsc_pkg::DSC_OFF_CTRL: begin
                    s_d.ctrl = dsc_merge(s_q.ctrl, wdata_in, wmask);
                end
                dsc_pkg::DSC_OFF_SENSE: begin
                    s_d.sense = dsc_merge(s_q.sense, wdata_in, wmask);
                end
                dsc_pkg::DSC_OFF_DEPOL: begin
                    s_d.depol = dsc_merge(s_q.depol, wdata_in, wmask);
                end
                dsc_pkg::DSC_OFF_PANEL: begin
                    s_d.panel = dsc_merge(s_q.panel, wdata_in, wmask);
                end
                dsc_pkg::DSC_OFF_STRAP: begin
                    s_d.strap = dsc_merge(s_q.strap, wdata_in, wmask);
                end
                dsc_pkg::DSC_OFF_RSV0: begin
                    s_d.rsv0 = dsc_merge(s_q.rsv0, wdata_in, wmask);
                end
                dsc_pkg::DSC_OFF_RSV1: begin
                    s_d.rsv1 = dsc_merge(s_q.rsv1, wdata_in, wmask);
                end
                default: begin
                    // read-only or unmapped: no store and no acknowledge
                    s_d.ack = 1'b0;
                end
            endcase
            // the pointer moves on after a refused byte as well
            s_d.addr = s_q.addr + 8'h01;
        end else if (rd_in) begin
            s_d.rdata  = dsc_rd_mux(s_q, irq_now, sense_now);
            s_d.rvalid = 1'b1;
            s_d.addr   = s_q.addr + 8'h01;
        end

        // ---------------------------------------------------------------
        // datapath controls
        // ---------------------------------------------------------------
        s_d.pd       = ~s_q.ctrl[dsc_pkg::DSC_B_RUN];
        pm_valid_byp = dsc_byp_ok(s_q.pm_s2);
        s_d.byp      = s_q.ctrl[dsc_pkg::DSC_B_BYPASS] & pm_valid_byp;
        s_d.clksel   = s_q.ctrl[dsc_pkg::DSC_B_CLKSEL];
        if (s_q.ctrl[dsc_pkg::DSC_B_HPASS]) begin
            s_d.hs = s_q.vid_s2[0];
        end else begin
            // pass disabled: the sync goes out as a fixed low
            s_d.hs = 1'b0;
        end
        if (s_q.ctrl[dsc_pkg::DSC_B_VPASS]) begin
            s_d.vs = s_q.vid_s2[1];
        end else begin
            s_d.vs = 1'b0;
        end
        if (s_q.depol[dsc_pkg::DSC_B_DEPOL]) begin
            s_d.de = s_q.vid_s2[2];
        end else begin
            s_d.de = ~s_q.vid_s2[2];
        end
        s_d.mon = dsc_mon_pick(monitor_pin_source_select, irq_now, sense_now);
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_q       <= '0;
            s_q.ctrl  <= dsc_pkg::DSC_RST_CTRL;
            s_q.sense <= dsc_pkg::DSC_RST_SENSE;
            s_q.depol <= dsc_pkg::DSC_RST_DEPOL;
        end else begin
            s_q <= s_d;
        end
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    assign rdata_out                   = s_q.rdata;
    assign ack_out                     = s_q.ack;
    assign rvalid_out                  = s_q.rvalid;
    assign soft_power_down_out         = s_q.pd;
    assign scaler_bypass_out           = s_q.byp;
    assign clock_input_type_select_out = s_q.clksel;
    assign hsync_out                   = s_q.hs;
    assign vsync_out                   = s_q.vs;
    assign de_active_out               = s_q.de;
    assign monitor_pin_output_out      = s_q.mon;
endmodule : dsc_regs

// [testbench/dsc_pin_model.sv]
// Purpose: far-side strap and status pins
// Assumes: levels change only on load_in
// Notes:   pins hold between loads, like straps
module dsc_pin_model (
    input  wire logic        clk_in,
    input  wire logic        load_in,
    input  wire logic [19:0] val_in,
    output logic      [19:0] pins_out = 20'h00000
);
    // mode, panel id, sense, low swing, lock, data, hsync, vsync, de
    always @(posedge clk_in) begin
        if (load_in) pins_out <= val_in;
    end
endmodule : dsc_pin_model

// [testbench/dsc_regs_assertions.sv]
// Purpose: port assertions for the register bank
// Assumes: one strobe at a time
// Notes:   pin paths get six or eight quiet cycles
module dsc_regs_chk (
    input wire logic       clk_in,
    input wire logic       rstn_in,
    input wire logic       addr_load_in,
    input wire logic [7:0] addr_in,
    input wire logic       wr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       rd_in,
    input wire logic [1:0] pixel_mode_in,
    input wire logic       hsync_in,
    input wire logic [7:0] rdata_out,
    input wire logic       ack_out,
    input wire logic       rvalid_out,
    input wire logic       soft_power_down_out,
    input wire logic       scaler_bypass_out,
    input wire logic       clock_input_type_select_out,
    input wire logic       hsync_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    a_ack_cause: assert property (ack_out |-> $past(wr_in) && !$past(addr_load_in))
        else $error("ack without write");
    a_read_answer: assert property (rd_in && !wr_in && !addr_load_in |=> rvalid_out)
        else $error("read not answered");
    a_rvalid_cause: assert property (rvalid_out |-> $past(rd_in))
        else $error("rvalid without read");
    a_rdata_hold: assert property (!rvalid_out |-> $stable(rdata_out))
        else $error("rdata moved");
    a_snap_refuse: assert property (
        addr_load_in && addr_in == 8'h0B ##1 wr_in && !addr_load_in |=> !ack_out)
        else $error("read-only write acked");
    a_ctrl_write: assert property (
        addr_load_in && addr_in == 8'h08 ##1 wr_in && !addr_load_in |=> ##1
        ($past(wdata_in, 2) & 8'h09) ==
        {4'h0, clock_input_type_select_out, 2'h0, !soft_power_down_out})
        else $error("ctrl bits not applied");
    a_hsync_low: assert property (!hsync_in [*6] |-> !hsync_out)
        else $error("hsync leaked");
    a_bypass_mode: assert property (pixel_mode_in[1] [*8] |-> !scaler_bypass_out)
        else $error("bypass in dual input mode");
endmodule : dsc_regs_chk

bind dsc_regs dsc_regs_chk i_chk (.clk_in(clk_in), .rstn_in(rstn_in), .rd_in(rd_in),
    .addr_load_in(addr_load_in), .addr_in(addr_in), .wr_in(wr_in), .wdata_in(wdata_in),
    .pixel_mode_in(pixel_mode_in), .hsync_in(hsync_in), .rdata_out(rdata_out),
    .ack_out(ack_out), .rvalid_out(rvalid_out), .soft_power_down_out(soft_power_down_out),
    .scaler_bypass_out(scaler_bypass_out), .hsync_out(hsync_out),
    .clock_input_type_select_out(clock_input_type_select_out));

// [testbench/testbench.sv]
// Purpose: self-checking bench for the register bank
// Assumes: pins settle within eight cycles
// Notes:   bus results queue in issue order
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in = 1'b0, rstn_in = 1'b0, ld = 1'b0, wr = 1'b0, rd = 1'b0, pld = 1'b0;
    logic        s_wr = 1'b0, s_rd = 1'b0, ack, rv, pd, byp, cks, hso, vso, deo, mon;
    logic [7:0]  bus = 8'h00, rdata, exp_q [$];
    logic [19:0] pv = 20'h00000, p;
    logic [7:0]  st [8] = '{8'h39, 8'h95, 8'h81, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0]  wm [8] = '{8'h3D, 8'h78, 8'hFF, 8'h00, 8'hF0, 8'hF0, 8'hFF, 8'hFF};
    int          n_mismatch = 0, comparisons = 0, cyc = 0;
    always #4 clk_in = ~clk_in;
    dsc_pin_model i_pins (.clk_in(clk_in), .load_in(pld), .val_in(pv), .pins_out(p));
    dsc_regs i_dut (.clk_in(clk_in), .rstn_in(rstn_in), .addr_load_in(ld), .addr_in(bus),
        .wr_in(wr), .wdata_in(bus), .rd_in(rd), .rdata_out(rdata), .ack_out(ack),
        .rvalid_out(rv), .pixel_mode_in(p[19:18]), .panel_identifier_pins_in(p[17:14]),
        .receiver_sense_in(p[13]), .low_swing_ref_in(p[12]), .pll_lock_in(p[11]),
        .input_data_high_in(p[10:3]), .hsync_in(p[2]), .vsync_in(p[1]), .de_in(p[0]),
        .soft_power_down_out(pd), .scaler_bypass_out(byp), .clock_input_type_select_out(cks),
        .hsync_out(hso), .vsync_out(vso), .de_active_out(deo), .monitor_pin_output_out(mon));
    function automatic logic [7:0] rdx(input int a);
        case (a)
            9: return {p[12], st[1][6:3], p[13], 1'b0, st[1][3] ? st[1][0] : p[13]};
            11: return p[10:3];
            12: return {st[4][7:4], p[17:14]};
            13: return {st[5][7:4], 1'b0, p[11], p[19:18]};
            16: return 8'h00;
            default: return st[a-8];
        endcase
    endfunction : rdx
    task automatic chk_bus(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_bus
    task automatic chk_pins(input logic [6:0] e, input logic [6:0] g);
        chk_bus("pins", {1'b0, e}, {1'b0, g});
    endtask : chk_pins
    task automatic strobe(input logic l, w, r, input logic [7:0] d);
        @(posedge clk_in);
        ld <= l;
        wr <= w;
        rd <= r;
        bus <= d;
    endtask : strobe
    // pointer loaded once, then one byte per cycle with auto-increment
    task automatic sweep(input logic w_en, input logic [2:0] ms, input int s);
        logic [7:0] v;
        strobe(1'b1, 1'b0, 1'b0, s[7:0]);
        for (int a = s; a <= 16; a++) begin
            v = $urandom;
            if (a == 9) v[6:4] = ms;
            if (a == 8 && ms == 3'h0) v[2] = 1'b1;
            if (w_en) exp_q.push_back({7'h0, a != 11 && a != 16});
            else exp_q.push_back(rdx(a));
            strobe(1'b0, w_en, !w_en, v);
            if (w_en && a < 16) st[a-8] = (st[a-8] & ~wm[a-8]) | (v & wm[a-8]);
        end
        strobe(1'b0, 1'b0, 1'b0, 8'h00);
    endtask : sweep
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
    always @(posedge clk_in) begin
        s_wr <= wr && !ld;
        s_rd <= rd && !wr && !ld;
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            final_report();
        end
    end
    always @(negedge clk_in) begin
        if (s_wr) chk_bus("ack", exp_q.pop_front(), {7'h0, ack});
        if (s_rd) chk_bus("rdata", exp_q.pop_front(), rv ? rdata : 8'hXX);
    end
    initial begin
        logic [2:0] ms;
        void'($urandom(32'h3B907FDB));
        repeat (16) @(posedge clk_in);
        rstn_in <= 1'b1;
        for (int it = 0; it < 9; it++) begin
            pv <= {it[1:0], 18'($urandom)};
            pld <= 1'b1;
            @(posedge clk_in);
            pld <= 1'b0;
            repeat (8) @(posedge clk_in);
            sweep(1'b0, 3'h0, 8);
            sweep(1'b1, 3'(it / 3), it % 3 == 0 ? 8 : 10 + it % 3);
            repeat (8) @(posedge clk_in);
            ms = st[1][6:4];
            chk_pins({!st[0][0], st[0][2] && !p[19], st[0][3], p[2] && st[0][4],
                p[1] && st[0][5], p[0] == st[2][0],
                ms == 3'h1 ? (st[1][3] ? st[1][0] : p[13]) : ms == 3'h2 && p[13]},
                {pd, byp, cks, hso, vso, deo, mon});
            $display("test %0d done", it);
        end
        sweep(1'b0, 3'h0, 8);
        repeat (2) @(posedge clk_in);
        final_report();
    end
endmodule : testbench
